//--- verilog/fifo_pkg.sv
// Operation
// - Store 1024 five-bit words, two clocks
// - Primary ignores writes full, reads empty
// - Secondary writes and reads without protection
// - Enables alone start or suppress transfers on secondary; primary also gates on full and empty
// - Write and read proceed in same period
// - Expansion: primary per depth, secondary per width
// - Delay mode: one clock, delay 2..1022
// - First read starts before full asserts
// - Load preset 800h minus delay while strobe low
// - Stages advance on write enable, carries chain
// - Count to 800h sets read, stops count
// - Read enable stays latched until reset or the next preset load
// - Flags change only on clock edges
// - Almost empty, almost full, half full warnings
// - Read data holds until next read edge
// - Full after 1024 writes, empty after reset
// - Write needs write enable high; read needs read enable or the delay latch
package fifo_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Storage geometry
    localparam int DATA_W  = 5;
    localparam int ADDR_W  = 10;
    localparam int PTR_W   = 11;
    localparam int DEPTH   = 1024;

    typedef logic [DATA_W-1:0] word_t;
    typedef logic [PTR_W-1:0]  ptr_t;

    // Flag thresholds, in stored words
    localparam ptr_t FULL_LEVEL   = 11'h400;
    localparam ptr_t HALF_LEVEL   = 11'h200;
    localparam ptr_t ALMOST_FULL  = 11'h3f8;
    localparam ptr_t ALMOST_EMPTY = 11'h008;

    ////////////////////////////////////////////////////////////////////////
    // Delay counter: three 4-bit stages
    localparam int STAGE_W = 4;
    localparam int STAGES  = 3;
    localparam int COUNT_W = 12;

    typedef logic [COUNT_W-1:0] count_t;

    localparam count_t TERMINAL_COUNT = 12'h800;
    localparam count_t DELAY_MIN      = 12'h002;
    localparam count_t DELAY_MAX      = 12'h3fe;
    localparam int     RUN_BIT        = 10;
    localparam int     TERMINAL_BIT   = 11;

    ////////////////////////////////////////////////////////////////////////
    // Controller registers on APB
    localparam logic [11:0] CTRL_OFFSET   = 12'h000;
    localparam logic [11:0] DELAY_OFFSET  = 12'h004;
    localparam logic [11:0] STATUS_OFFSET = 12'h008;
    localparam logic [11:0] INT_OFFSET    = 12'h00c;
    localparam logic [11:0] MASK_OFFSET   = 12'h010;

    localparam int CTRL_WRITE_BIT  = 0;
    localparam int CTRL_READ_BIT   = 1;
    localparam int CTRL_DELAY_BIT  = 2;
    localparam int CTRL_RUN_BIT    = 3;
    localparam int CTRL_LOAD_N_BIT = 4;
    localparam int CTRL_W          = 5;

    localparam logic [CTRL_W-1:0] CTRL_RESET  = 5'h10;
    localparam count_t            DELAY_RESET = 12'h3fe;

    // Interrupt events
    localparam int INT_FULL  = 0;
    localparam int INT_EMPTY = 1;
    localparam int INT_AFULL = 2;
    localparam int INT_W     = 3;

endpackage : fifo_pkg

//--- verilog/fifo_link_if.sv
`timescale 1ns/1ps
// Link between the buffer and its producer/consumer controller
interface fifo_link_if (
    input wire logic pclk
);
    import fifo_pkg::*;

    logic   write_clock;
    logic   read_clock;
    logic   reset_n;
    logic   write_enable_primary;
    logic   read_enable_primary;
    logic   delay_mode;
    logic   count_load_n;
    count_t delay_preset;
    word_t  write_data;
    word_t  read_data;
    logic   read_strobe;
    logic   full_flag_n;
    logic   empty_flag_n;
    logic   almost_empty_flag;
    logic   almost_full_flag;
    logic   half_full_flag;

    // One free-running system clock feeds both sides
    assign write_clock = pclk;
    assign read_clock  = pclk;

    modport device (
        input  write_clock, read_clock, reset_n, write_enable_primary,
        input  read_enable_primary, delay_mode, count_load_n,
        input  delay_preset, write_data,
        output read_data, read_strobe, full_flag_n, empty_flag_n,
        output almost_empty_flag, almost_full_flag, half_full_flag
    );

    modport host (
        output reset_n, write_enable_primary, read_enable_primary,
        output delay_mode, count_load_n, delay_preset, write_data,
        input  read_data, read_strobe, full_flag_n, empty_flag_n,
        input  almost_empty_flag, almost_full_flag, half_full_flag
    );

endinterface : fifo_link_if

//--- verilog/delay_counter.sv
`timescale 1ns/1ps
// Cascaded preset counter that opens the read port after a delay
module delay_counter (
    input  wire logic            clock,
    input  wire logic            reset_n,
    input  wire logic            count_load_n,
    input  wire logic            count_parallel_enable,
    input  wire fifo_pkg::count_t preset,
    output logic                 read_enable_latched
);
    import fifo_pkg::*;

    logic [STAGE_W-1:0] stage_q [STAGES];
    logic [STAGES-1:0]  count_trickle_enable;
    logic [STAGES-1:0]  stage_carry_out;
    logic               count_run_bit;

    // First stage runs while the run bit is set
    assign count_run_bit = stage_q[STAGES-1][RUN_BIT-2*STAGE_W];

    ////////////////////////////////////////////////////////////////////////
    genvar g;
    generate
        for (g = 0; g < STAGES; g++) begin : g_stage
            // Carry of each stage enables the next
            if (g == 0) begin : g_first
                assign count_trickle_enable[g] = count_run_bit;
            end else begin : g_next
                assign count_trickle_enable[g] = stage_carry_out[g-1];
            end
            assign stage_carry_out[g] = count_trickle_enable[g]
                                      & (&stage_q[g]);

            // Load, then count while write enable high
            always_ff @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    stage_q[g] <= 4'h0;
                end else if (!count_load_n) begin
                    stage_q[g] <= preset[g*STAGE_W +: STAGE_W];
                end else if (count_parallel_enable
                             && count_trickle_enable[g]) begin
                    stage_q[g] <= stage_q[g] + 4'h1;
                end
            end
        end
    endgenerate

    // Terminal bit holds once the run bit has cleared
    assign read_enable_latched =
        stage_q[STAGES-1][TERMINAL_BIT-2*STAGE_W];

endmodule : delay_counter

//--- verilog/fifo_device.sv
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
// Clocked first-in-first-out buffer, 1024 words of five bits
module fifo_device #(
    parameter bit PRIMARY = 1'b1
) (
    fifo_link_if.device     link,
    output fifo_pkg::ptr_t  fill_level
);
    import fifo_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    // Storage array, flip-flops addressed by pointer
    word_t mem [DEPTH];

    // Write side
    ptr_t  wptr;
    ptr_t  next_wptr;
    ptr_t  wgray;
    ptr_t  rgray_sync1;
    ptr_t  rgray_sync2;
    ptr_t  rptr_seen;
    ptr_t  next_wcount;
    ptr_t  wcount;
    logic  wr_go;
    logic  full_n;
    logic  afull;
    logic  hfull;

    // Read side
    ptr_t  rptr;
    ptr_t  next_rptr;
    ptr_t  rgray;
    ptr_t  wgray_sync1;
    ptr_t  wgray_sync2;
    ptr_t  wptr_seen;
    ptr_t  next_rcount;
    logic  rd_en;
    logic  rd_go;
    logic  empty_n;
    logic  aempty;
    logic  rd_strobe;
    word_t rd_word;

    // Delay control
    logic  delay_read_enable;

    ////////////////////////////////////////////////////////////////////////
    // Pointer code conversion

    function automatic ptr_t to_gray(input ptr_t b);
        return b ^ (b >> 1);
    endfunction : to_gray

    function automatic ptr_t to_bin(input ptr_t g);
        ptr_t b;
        b = '0;
        b[PTR_W-1] = g[PTR_W-1];
        for (int i = PTR_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : to_bin

    ////////////////////////////////////////////////////////////////////////
    // Delay counter on the system clock

    // Write enable steers both the buffer and the counter
    delay_counter u_delay (
        .clock                 (link.write_clock),
        .reset_n               (link.reset_n),
        .count_load_n          (link.count_load_n),
        .count_parallel_enable (link.write_enable_primary),
        .preset                (link.delay_preset),
        .read_enable_latched   (delay_read_enable)
    );

    ////////////////////////////////////////////////////////////////////////
    // Write side qualification

    // Enable AND not-full on primary; enable only on secondary
    assign wr_go = link.write_enable_primary
                 & (full_n | ~PRIMARY);

    assign next_wptr = wr_go ? wptr + 11'h001 : wptr;

    // In delay mode the common clock sees this edge's read at once, no lag
    assign rptr_seen = link.delay_mode ? next_rptr : to_bin(rgray_sync2);

    assign next_wcount = next_wptr - rptr_seen;

    ////////////////////////////////////////////////////////////////////////
    // Storage write port, independent of the read port

    always_ff @(posedge link.write_clock) begin
        if (wr_go) begin
            mem[wptr[ADDR_W-1:0]] <= link.write_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write pointer and read pointer synchroniser

    always_ff @(posedge link.write_clock or negedge link.reset_n) begin
        if (!link.reset_n) begin
            wptr        <= '0;
            wgray       <= '0;
            rgray_sync1 <= '0;
            rgray_sync2 <= '0;
        end else begin
            wptr        <= next_wptr;
            wgray       <= to_gray(next_wptr);
            rgray_sync1 <= rgray;
            rgray_sync2 <= rgray_sync1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write-side flags, latched on the write clock

    // Full only once all 1024 locations hold data
    always_ff @(posedge link.write_clock or negedge link.reset_n) begin
        if (!link.reset_n) begin
            full_n <= 1'b1;
            afull  <= 1'b0;
            hfull  <= 1'b0;
            wcount <= '0;
        end else begin
            full_n <= (next_wcount != FULL_LEVEL);
            afull  <= (next_wcount >= ALMOST_FULL);
            hfull  <= (next_wcount >= HALF_LEVEL);
            wcount <= next_wcount;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read side qualification

    // Delay mode takes the read enable from the counter
    assign rd_en = link.delay_mode ? delay_read_enable
                                   : link.read_enable_primary;

    // Enable AND not-empty on primary; enable only on secondary
    assign rd_go = rd_en & (empty_n | ~PRIMARY);

    assign next_rptr = rd_go ? rptr + 11'h001 : rptr;

    assign wptr_seen = link.delay_mode ? next_wptr : to_bin(wgray_sync2);

    assign next_rcount = wptr_seen - next_rptr;

    ////////////////////////////////////////////////////////////////////////
    // Output latch: holds until the next read edge

    always_ff @(posedge link.read_clock or negedge link.reset_n) begin
        if (!link.reset_n) begin
            rd_word   <= '0;
            rd_strobe <= 1'b0;
        end else begin
            rd_strobe <= rd_go;
            if (rd_go) begin
                rd_word <= mem[rptr[ADDR_W-1:0]];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read pointer and write pointer synchroniser

    always_ff @(posedge link.read_clock or negedge link.reset_n) begin
        if (!link.reset_n) begin
            rptr        <= '0;
            rgray       <= '0;
            wgray_sync1 <= '0;
            wgray_sync2 <= '0;
        end else begin
            rptr        <= next_rptr;
            rgray       <= to_gray(next_rptr);
            wgray_sync1 <= wgray;
            wgray_sync2 <= wgray_sync1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read-side flags, latched on the read clock

    // Empty after reset or after the last stored word
    always_ff @(posedge link.read_clock or negedge link.reset_n) begin
        if (!link.reset_n) begin
            empty_n <= 1'b0;
            aempty  <= 1'b1;
        end else begin
            empty_n <= (next_rcount != 11'h000);
            aempty  <= (next_rcount <= ALMOST_EMPTY);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flip-flops

    assign link.read_data         = rd_word;
    assign link.read_strobe       = rd_strobe;
    assign link.full_flag_n       = full_n;
    assign link.empty_flag_n      = empty_n;
    assign link.almost_full_flag  = afull;
    assign link.almost_empty_flag = aempty;
    assign link.half_full_flag    = hfull;
    assign fill_level             = wcount;

endmodule : fifo_device

//--- verilog/fifo_host.sv
`timescale 1ns/1ps
// Producer/consumer controller with APB registers
module fifo_host (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic [11:0]   paddr,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    output logic               irq,
    input  wire fifo_pkg::word_t src_data,
    output fifo_pkg::word_t    sink_data,
    output logic               sink_valid,
    fifo_link_if.host          link
);
    import fifo_pkg::*;

    logic [CTRL_W-1:0] ctrl;
    count_t            delay;
    count_t            preset;
    logic [INT_W-1:0]  int_status;
    logic [INT_W-1:0]  int_mask;
    logic [INT_W-1:0]  events;
    logic [INT_W-1:0]  next_int;
    logic [2:0]        prev_flags;
    word_t             wr_word;
    word_t             rd_word;
    logic              rd_valid;
    logic              access;
    logic              wr_take;
    logic              hit_ctrl;
    logic              hit_delay;
    logic              hit_status;
    logic              hit_int;
    logic              hit_mask;
    logic              mapped;
    logic [31:0]       rd_value;
    count_t            delay_in;

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    assign access     = psel & penable & pready;
    assign wr_take    = access & pwrite;
    assign hit_ctrl   = (paddr == CTRL_OFFSET);
    assign hit_delay  = (paddr == DELAY_OFFSET);
    assign hit_status = (paddr == STATUS_OFFSET);
    assign hit_int    = (paddr == INT_OFFSET);
    assign hit_mask   = (paddr == MASK_OFFSET);
    assign mapped     = hit_ctrl | hit_delay | hit_status | hit_int
                      | hit_mask;

    // Read selection
    assign rd_value = hit_ctrl   ? {27'h0, ctrl} :
                      hit_delay  ? {20'h0, delay} :
                      hit_status ? {27'h0, link.half_full_flag,
                                    link.almost_full_flag,
                                    link.almost_empty_flag,
                                    link.full_flag_n, link.empty_flag_n} :
                      hit_int    ? {29'h0, int_status} :
                      hit_mask   ? {29'h0, int_mask} : 32'h0;

    // Delay kept inside 2..1022 so full never asserts
    assign delay_in = (pwdata[11:0] < DELAY_MIN) ? DELAY_MIN :
                      (pwdata[11:0] > DELAY_MAX) ? DELAY_MAX : pwdata[11:0];

    // Preset is 800h minus the wanted delay
    assign preset = TERMINAL_COUNT - delay;

    // Events: full reached, empty reached, almost full reached
    assign events = {~prev_flags[2] & link.almost_full_flag,
                     prev_flags[1] & ~link.empty_flag_n,
                     prev_flags[0] & ~link.full_flag_n};
    // Set beats write-one-to-clear
    assign next_int = (int_status
                       & ~((hit_int & wr_take) ? pwdata[INT_W-1:0] : 3'h0))
                    | events;

    ////////////////////////////////////////////////////////////////////////
    // APB slave: no wait state, answer in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable & ~pready;
            prdata  <= rd_value;
            pslverr <= psel & ~penable & ~mapped;
        end
    end

    // Register writes; ctrl bits drive the link directly
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl     <= CTRL_RESET;
            delay    <= DELAY_RESET;
            int_mask <= 3'h0;
        end else if (wr_take) begin
            if (hit_ctrl) begin
                ctrl <= pwdata[CTRL_W-1:0];
            end else if (hit_delay) begin
                delay <= delay_in;
            end else if (hit_mask) begin
                int_mask <= pwdata[INT_W-1:0];
            end
        end
    end

    // Interrupts and data path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status <= 3'h0;
            irq        <= 1'b0;
            prev_flags <= 3'h1; // Idle levels while the buffer is held reset
            wr_word    <= '0;
            rd_word    <= '0;
            rd_valid   <= 1'b0;
        end else begin
            int_status <= next_int;
            irq        <= |(next_int & int_mask);
            prev_flags <= {link.almost_full_flag, link.empty_flag_n,
                           link.full_flag_n};
            wr_word    <= src_data;
            rd_word    <= link.read_data;
            rd_valid   <= link.read_strobe;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link outputs from flip-flops; preset is 800h minus the delay register
    assign link.reset_n              = ctrl[CTRL_RUN_BIT];
    assign link.write_enable_primary = ctrl[CTRL_WRITE_BIT];
    assign link.read_enable_primary  = ctrl[CTRL_READ_BIT];
    assign link.delay_mode           = ctrl[CTRL_DELAY_BIT];
    assign link.count_load_n         = ctrl[CTRL_LOAD_N_BIT];
    assign link.delay_preset         = preset;
    assign link.write_data           = wr_word;
    assign sink_data                 = rd_word;
    assign sink_valid                = rd_valid;

endmodule : fifo_host

//--- sim/fifo_link_monitor.sv
`timescale 1ns/1ps
// Watches the link between controller and buffer
module fifo_link_monitor (
    input wire logic            pclk,
    input wire logic            reset_n,
    input wire logic            write_enable_primary,
    input wire logic            read_enable_primary,
    input wire logic            delay_mode,
    input wire fifo_pkg::word_t read_data,
    input wire logic            read_strobe,
    input wire logic            full_flag_n,
    input wire logic            empty_flag_n,
    input wire logic            almost_empty_flag,
    input wire logic            almost_full_flag,
    input wire logic            half_full_flag
);
    import fifo_pkg::*;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////
    // Quiet windows, long enough to cover pointer sync lag
    sequence s_no_read;
        (!read_enable_primary && !delay_mode)[*4];
    endsequence
    sequence s_no_write;
        (!write_enable_primary)[*4];
    endsequence
    sequence s_first_write;
        delay_mode && write_enable_primary && !empty_flag_n;
    endsequence

    ////////////////////////////////////////////////////////////
    // Transfer and flag relations
    property p_strobe_cause;
        read_strobe && !$past(delay_mode)
            |-> $past(read_enable_primary && empty_flag_n);
    endproperty
    property p_data_hold;
        !read_strobe |-> $stable(read_data);
    endproperty
    property p_flags_excl;
        full_flag_n || empty_flag_n;
    endproperty
    property p_full_hold;
        s_no_read ##0 !full_flag_n |=> !full_flag_n;
    endproperty
    property p_empty_hold;
        s_no_write ##0 !empty_flag_n |=> !empty_flag_n;
    endproperty
    property p_warn_low;
        half_full_flag |-> !almost_empty_flag && empty_flag_n;
    endproperty
    property p_warn_high;
        !full_flag_n |-> almost_full_flag && half_full_flag;
    endproperty
    property p_read_latched;
        delay_mode && write_enable_primary && read_strobe
            && $past(delay_mode && write_enable_primary) |=> read_strobe;
    endproperty
    property p_empty_clear;
        s_first_write |=> empty_flag_n;
    endproperty

    a_strobe_cause:
        assert property (p_strobe_cause) else $error("read without cause");
    a_data_hold:
        assert property (p_data_hold) else $error("read data moved");
    a_flags_excl:
        assert property (p_flags_excl) else $error("full and empty both");
    a_full_hold:
        assert property (p_full_hold) else $error("full dropped idle");
    a_empty_hold:
        assert property (p_empty_hold) else $error("empty dropped idle");
    a_warn_low:
        assert property (p_warn_low) else $error("low warnings clash");
    a_warn_high:
        assert property (p_warn_high) else $error("high warnings missing");
    a_read_latched:
        assert property (p_read_latched) else $error("delayed read stopped");
    a_empty_clear:
        assert property (p_empty_clear) else $error("empty not cleared");

endmodule : fifo_link_monitor

//--- sim/clocked_fifo_digital_delay_tb_top.sv
`timescale 1ns/1ps
// Drives the controller over APB and watches the delayed stream
module clocked_fifo_digital_delay_tb_top;
    import fifo_pkg::*;

    localparam int LIMIT = 8000;

    logic        pclk;
    logic        presetn;
    logic [11:0] paddr;
    logic        psel, penable, pwrite, pready, pslverr, irq, err;
    logic [31:0] pwdata, prdata, rd;
    logic        sink_valid;
    word_t       src_data, sink_data, last;
    ptr_t        fill_level;
    int          failures, n_checks, n_sink, cycles;
    bit          have_last;

    fifo_link_if fifo_link_if_inst (.pclk(pclk));

    fifo_host fifo_host_inst (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .src_data(src_data), .sink_data(sink_data),
        .sink_valid(sink_valid), .link(fifo_link_if_inst)
    );

    fifo_device #(.PRIMARY(1'b1)) fifo_device_inst (
        .link(fifo_link_if_inst), .fill_level(fill_level)
    );

    fifo_link_monitor fifo_link_monitor_inst (
        .pclk(pclk),
        .reset_n(fifo_link_if_inst.reset_n),
        .write_enable_primary(fifo_link_if_inst.write_enable_primary),
        .read_enable_primary(fifo_link_if_inst.read_enable_primary),
        .delay_mode(fifo_link_if_inst.delay_mode),
        .read_data(fifo_link_if_inst.read_data),
        .read_strobe(fifo_link_if_inst.read_strobe),
        .full_flag_n(fifo_link_if_inst.full_flag_n),
        .empty_flag_n(fifo_link_if_inst.empty_flag_n),
        .almost_empty_flag(fifo_link_if_inst.almost_empty_flag),
        .almost_full_flag(fifo_link_if_inst.almost_full_flag),
        .half_full_flag(fifo_link_if_inst.half_full_flag)
    );

    ////////////////////////////////////////////////////////////
    // Clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////
    // Helpers
    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic stop_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    // One APB transfer; read data and error land in rd and err
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Delay mode run with delay d, then level and status
    task automatic run_delay(input logic [31:0] d, input logic [31:0] st);
        apb(1'b1, DELAY_OFFSET, d);
        apb(1'b1, CTRL_OFFSET, 32'h0);
        apb(1'b1, CTRL_OFFSET, 32'h08);
        apb(1'b1, CTRL_OFFSET, 32'h1c);
        have_last = 1'b0;
        apb(1'b1, CTRL_OFFSET, 32'h1d);
        repeat (d + 40) @(posedge pclk);
        chk("fill_level", d, 32'(fill_level));
        chk("full_flag_n", 1, fifo_link_if_inst.full_flag_n);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk("status", st, rd);
    endtask : run_delay

    ////////////////////////////////////////////////////////////
    // Source counter, sink order check and timeout
    always @(posedge pclk) begin
        src_data <= src_data + 5'h01;
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            stop_test();
        end
        if (sink_valid === 1'b1) begin
            if (have_last) begin
                chk("sink_data", word_t'(last + 5'h01), sink_data);
            end
            last = sink_data;
            have_last = 1'b1;
            n_sink++;
        end
    end

    ////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        src_data = '0;
        presetn = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, CTRL_OFFSET, 32'h0);
        chk("ctrl_reset", 32'h10, rd);
        apb(1'b0, DELAY_OFFSET, 32'h0);
        chk("delay_reset", 32'h3fe, rd);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk("status_reset", 32'h06, rd);
        apb(1'b0, INT_OFFSET, 32'h0);
        chk("int_reset", 32'h0, rd);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped_err", 1, err);
        apb(1'b1, DELAY_OFFSET, 32'h1);
        apb(1'b0, DELAY_OFFSET, 32'h0);
        chk("delay_min", 32'h2, rd);
        apb(1'b1, DELAY_OFFSET, 32'hfff);
        apb(1'b0, DELAY_OFFSET, 32'h0);
        chk("delay_max", 32'h3fe, rd);
        run_delay(32'h2, 32'h07);
        run_delay(32'h3fe, 32'h1b);
        // Fill until writes are refused
        apb(1'b1, CTRL_OFFSET, 32'h0);
        apb(1'b1, CTRL_OFFSET, 32'h18);
        apb(1'b1, MASK_OFFSET, 32'h0);
        apb(1'b1, INT_OFFSET, 32'h7);
        have_last = 1'b0;
        n_sink = 0;
        apb(1'b1, CTRL_OFFSET, 32'h19);
        repeat (1100) @(posedge pclk);
        chk("fill_full", 32'h400, 32'(fill_level));
        chk("full_flag_n", 0, fifo_link_if_inst.full_flag_n);
        chk("irq_masked", 0, irq);
        apb(1'b0, INT_OFFSET, 32'h0);
        chk("int_full", 1, rd[INT_FULL]);
        apb(1'b1, MASK_OFFSET, 32'h1);
        repeat (2) @(posedge pclk);
        chk("irq_on", 1, irq);
        apb(1'b1, INT_OFFSET, 32'h1);
        repeat (2) @(posedge pclk);
        apb(1'b0, INT_OFFSET, 32'h0);
        chk("int_clear", 0, rd[INT_FULL]);
        chk("irq_off", 0, irq);
        // Drain until reads are refused
        apb(1'b1, CTRL_OFFSET, 32'h1a);
        repeat (1100) @(posedge pclk);
        chk("sink_count", 1024, n_sink);
        chk("empty_flag_n", 0, fifo_link_if_inst.empty_flag_n);
        chk("fill_empty", 0, 32'(fill_level));
        apb(1'b0, INT_OFFSET, 32'h0);
        chk("int_empty", 1, rd[INT_EMPTY]);
        stop_test();
    end

endmodule : clocked_fifo_digital_delay_tb_top
